// >>> fifo_byte_mem.sv
// byte memory of one fifo with a registered, write-through read port
`timescale 1ns/1ps

module fifo_byte_mem
    import smbus_fifo_pkg::*;
(
    // clock and reset
    input  wire logic  core_clk_i,
    input  wire logic  reset_i,
    // write port
    input  wire logic  wr_en_i,
    input  wire ptr_t  wr_addr_i,
    input  wire byte_t wr_data_i,
    // read port, data one cycle after the address
    input  wire ptr_t  rd_addr_i,
    output byte_t      rd_data_o
);

    mem_state_t st_reg;
    mem_state_t st_next;

    // reading from the next state gives write-through on a same-slot write,
    // so a byte pushed into an empty fifo is at the head one cycle later
    always_comb begin
        st_next = st_reg;
        if (wr_en_i) begin
            st_next.entry[wr_addr_i] = wr_data_i;
        end
        st_next.rdata = st_next.entry[rd_addr_i];
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data_o = st_reg.rdata;

endmodule : fifo_byte_mem

// >>> smbus_engine_model.sv
// behavioural model of the serial engine facing the fifo port
`timescale 1ns/1ps

module smbus_engine_model
    import smbus_fifo_pkg::*;
(
    // clock
    input  wire logic  core_clk_i,
    // transmit side
    input  wire logic  tx_valid_i,
    input  wire byte_t tx_data_i,
    output logic       tx_pop_o,
    // receive side
    input  wire logic  rx_ready_i,
    output logic       rx_push_o,
    output byte_t      rx_data_o
);

    initial begin
        tx_pop_o = 1'b0;
        rx_push_o = 1'b0;
        rx_data_o = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // pushes even when not ready, so refusal can be provoked on purpose;
    // the inverse is left behind so a late sample never matches stale data
    task automatic push_byte(input byte_t b);
        @(posedge core_clk_i);
        rx_push_o <= 1'b1;
        rx_data_o <= b;
        @(posedge core_clk_i);
        rx_push_o <= 1'b0;
        rx_data_o <= ~b;
    endtask : push_byte

    // stall models a slow engine before it takes the head byte
    task automatic pop_byte(input int stall, output byte_t b, output logic ok);
        repeat (stall) @(posedge core_clk_i);
        @(negedge core_clk_i);
        b = tx_data_i;
        ok = tx_valid_i;
        @(posedge core_clk_i);
        tx_pop_o <= 1'b1;
        @(posedge core_clk_i);
        tx_pop_o <= 1'b0;
    endtask : pop_byte

endmodule : smbus_engine_model

// >>> smbus_fifo_pkg.sv
// types shared by the smbus fifo port and its byte memory
`include "smbus_fifo_regs.svh"

package smbus_fifo_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [1:0] ptr_t;
    typedef logic [2:0] cnt_t;

    // register port request, all fields sampled in one cycle
    typedef struct packed {
        logic  [7:0] addr;
        byte_t       wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // control register in its bit order, msb first
    typedef struct packed {
        logic       tx_irq_en;
        logic       tx_flush;
        logic [1:0] tx_th;
        logic       rx_irq_en;
        logic       rx_flush;
        logic [1:0] rx_th;
    } ctrl_t;

    // sticky events, same layout for status and mask
    typedef struct packed {
        logic rx_overflow;
        logic rx_underrun;
        logic tx_overwrite;
    } evt_t;

    typedef struct packed {
        byte_t [`FIFO_ENTRIES-1:0] entry;
        byte_t                     rdata;
    } mem_state_t;

    typedef struct packed {
        ctrl_t ctrl;
        evt_t  evt;
        evt_t  mask;
        ptr_t  tx_wr;
        ptr_t  tx_rd;
        cnt_t  tx_cnt;
        ptr_t  rx_wr;
        ptr_t  rx_rd;
        cnt_t  rx_cnt;
        byte_t last_rx;
        byte_t rd_data;
        logic  tx_valid;
        logic  rx_ready;
        logic  irq;
    } state_t;

endpackage : smbus_fifo_pkg

// >>> smbus_fifo_regs.svh
// register offsets, field positions and reset values of the smbus fifo port
// How it works
// - writing the data register pushes the byte into the transmit fifo
// - writing while the transmit fifo is full replaces the newest queued byte
// - reading while the receive fifo is empty returns the last byte held
// - transmit request enable lets the transmit request flag raise the interrupt
// - transmit flush empties the transmit fifo, self clears after one cycle
// - transmit request is set while transmit count is at most the threshold
// - transmit threshold zero requests only when the transmit fifo is empty
// - receive request enable lets the receive request flag raise the interrupt
// - reading the data register pops the receive fifo
// - receive flush empties the receive fifo, self clears after one cycle
// - receive request is set while receive count exceeds the threshold
// - transmit not full reads one while room remains, zero when full
`ifndef SMBUS_FIFO_REGS_SVH
`define SMBUS_FIFO_REGS_SVH

// register offsets on the register port
`define DATA_OFS        8'hC2
`define CTRL_OFS        8'hC3
`define STAT_OFS        8'hC4
`define EVT_OFS         8'hC5
`define MASK_OFS        8'hC6

// control field positions
`define CTRL_TX_IRQ_EN  7
`define CTRL_TX_FLUSH   6
`define CTRL_TX_TH_HI   5
`define CTRL_TX_TH_LO   4
`define CTRL_RX_IRQ_EN  3
`define CTRL_RX_FLUSH   2
`define CTRL_RX_TH_HI   1
`define CTRL_RX_TH_LO   0

// status field positions
`define STAT_TX_REQ     7
`define STAT_TX_NF      6
`define STAT_RX_REQ     3
`define STAT_RX_EMPTY   2

// reset values
`define CTRL_RESET      8'h00
`define EVT_RESET       3'h0
`define DATA_RESET      8'h00

// fifo geometry and counts
`define FIFO_ENTRIES    4
`define FIFO_DEPTH      3'h4
`define CNT_ZERO        3'h0
`define CNT_ONE         3'h1
`define PTR_ONE         2'h1

`endif

// >>> smbus_tx_rx_fifo_port.sv
// smbus fifo port: data and control registers, both byte fifos, interrupt
`timescale 1ns/1ps
`include "smbus_fifo_regs.svh"

module smbus_tx_rx_fifo_port
    import smbus_fifo_pkg::*;
(
    // clock and reset
    input  wire logic     core_clk_i,
    input  wire logic     reset_i,
    // register port
    input  wire reg_req_t reg_req_i,
    output byte_t         rd_data_o,
    // serial engine, transmit side
    input  wire logic     tx_pop_i,
    output logic          tx_valid_o,
    output byte_t         tx_data_o,
    // serial engine, receive side
    input  wire logic     rx_push_i,
    input  wire byte_t    rx_data_i,
    output logic          rx_ready_o,
    // interrupt
    output logic          irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    state_t st_reg;
    state_t st_next;

    logic  data_wr;
    logic  data_rd;
    logic  ctrl_wr;
    logic  ctrl_rd;
    logic  stat_rd;
    logic  evt_rd;
    logic  mask_wr;
    logic  mask_rd;

    logic  tx_req;
    logic  rx_req;
    logic  tx_not_full;
    logic  rx_empty;
    logic  tx_pop;
    logic  tx_push;
    logic  rx_pop;
    logic  rx_push;
    evt_t  evt_set;

    logic  tx_we;
    ptr_t  tx_waddr;
    logic  rx_we;
    byte_t tx_rdata;
    byte_t rx_rdata;
    byte_t status_byte;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    always_comb begin
        data_wr = 1'b0;
        data_rd = 1'b0;
        ctrl_wr = 1'b0;
        ctrl_rd = 1'b0;
        stat_rd = 1'b0;
        evt_rd  = 1'b0;
        mask_wr = 1'b0;
        mask_rd = 1'b0;
        if (reg_req_i.addr == `DATA_OFS) begin
            data_wr = reg_req_i.wr;
            data_rd = reg_req_i.rd;
        end else if (reg_req_i.addr == `CTRL_OFS) begin
            ctrl_wr = reg_req_i.wr;
            ctrl_rd = reg_req_i.rd;
        end else if (reg_req_i.addr == `STAT_OFS) begin
            stat_rd = reg_req_i.rd;
        end else if (reg_req_i.addr == `EVT_OFS) begin
            evt_rd  = reg_req_i.rd;
        end else if (reg_req_i.addr == `MASK_OFS) begin
            mask_wr = reg_req_i.wr;
            mask_rd = reg_req_i.rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags seen by software and the engine

    // transmit threshold zero only matches an empty fifo
    assign tx_req      = st_reg.tx_cnt <= {1'b0, st_reg.ctrl.tx_th};
    assign rx_req      = st_reg.rx_cnt > {1'b0, st_reg.ctrl.rx_th};
    // room left in the transmit fifo
    assign tx_not_full = st_reg.tx_cnt != `FIFO_DEPTH;
    assign rx_empty    = st_reg.rx_cnt == `CNT_ZERO;

    always_comb begin
        status_byte = 8'h00;
        status_byte[`STAT_TX_REQ]   = tx_req;
        status_byte[`STAT_TX_NF]    = tx_not_full;
        status_byte[`STAT_RX_REQ]   = rx_req;
        status_byte[`STAT_RX_EMPTY] = rx_empty;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_next  = st_reg;
        tx_we    = 1'b0;
        tx_waddr = st_reg.tx_wr;
        rx_we    = 1'b0;

        // fifo strobes are dropped while a flush is in progress
        tx_pop  = tx_pop_i && (st_reg.tx_cnt != `CNT_ZERO)
                  && !st_reg.ctrl.tx_flush;
        tx_push = data_wr && tx_not_full && !st_reg.ctrl.tx_flush;
        rx_push = rx_push_i && (st_reg.rx_cnt != `FIFO_DEPTH)
                  && !st_reg.ctrl.rx_flush;
        // data reads pop the receive fifo
        rx_pop  = data_rd && !rx_empty && !st_reg.ctrl.rx_flush;

        evt_set.tx_overwrite = data_wr && !tx_not_full
                               && !st_reg.ctrl.tx_flush;
        evt_set.rx_underrun  = data_rd && rx_empty;
        evt_set.rx_overflow  = rx_push_i && !st_reg.ctrl.rx_flush
                               && (st_reg.rx_cnt == `FIFO_DEPTH);

        // transmit side
        if (tx_pop) begin
            st_next.tx_rd = st_reg.tx_rd + `PTR_ONE;
        end
        if (tx_push) begin
            tx_we         = 1'b1;
            st_next.tx_wr = st_reg.tx_wr + `PTR_ONE;
        end else if (evt_set.tx_overwrite) begin
            // full: overwrite the newest entry, count unchanged
            tx_we    = 1'b1;
            tx_waddr = st_reg.tx_wr - `PTR_ONE;
        end
        st_next.tx_cnt = st_reg.tx_cnt + (tx_push ? `CNT_ONE : `CNT_ZERO)
                         - (tx_pop ? `CNT_ONE : `CNT_ZERO);

        // receive side
        if (rx_push) begin
            rx_we         = 1'b1;
            st_next.rx_wr = st_reg.rx_wr + `PTR_ONE;
        end
        st_next.rd_data = `DATA_RESET;
        if (rx_pop) begin
            st_next.rx_rd   = st_reg.rx_rd + `PTR_ONE;
            st_next.rd_data = rx_rdata;
            st_next.last_rx = rx_rdata;
        end else if (data_rd) begin
            // empty fifo: repeat the last byte, no underflow
            st_next.rd_data = st_reg.last_rx;
        end
        st_next.rx_cnt = st_reg.rx_cnt + (rx_push ? `CNT_ONE : `CNT_ZERO)
                         - (rx_pop ? `CNT_ONE : `CNT_ZERO);

        // transmit flush drops counters and self clears
        if (st_reg.ctrl.tx_flush) begin
            st_next.tx_wr         = '0;
            st_next.tx_rd         = '0;
            st_next.tx_cnt        = `CNT_ZERO;
            st_next.ctrl.tx_flush = 1'b0;
        end
        // receive flush drops counters and self clears
        if (st_reg.ctrl.rx_flush) begin
            st_next.rx_wr         = '0;
            st_next.rx_rd         = '0;
            st_next.rx_cnt        = `CNT_ZERO;
            st_next.ctrl.rx_flush = 1'b0;
        end

        // other register reads
        if (ctrl_rd) begin
            st_next.rd_data = st_reg.ctrl;
        end else if (stat_rd) begin
            st_next.rd_data = status_byte;
        end else if (evt_rd) begin
            st_next.rd_data = {5'h00, st_reg.evt};
        end else if (mask_rd) begin
            st_next.rd_data = {5'h00, st_reg.mask};
        end

        // a write after the self clear so a fresh flush request is kept
        if (ctrl_wr) begin
            st_next.ctrl = ctrl_t'(reg_req_i.wdata);
        end
        if (mask_wr) begin
            st_next.mask = evt_t'(reg_req_i.wdata[2:0]);
        end

        // read clears the sticky events, a new event in that cycle wins
        st_next.evt = (evt_rd ? `EVT_RESET : st_reg.evt) | evt_set;

        st_next.tx_valid = st_next.tx_cnt != `CNT_ZERO;
        st_next.rx_ready = st_next.rx_cnt != `FIFO_DEPTH;

        // transmit request gated by its enable
        // receive request gated by its enable
        st_next.irq =
            ((st_next.tx_cnt <= {1'b0, st_next.ctrl.tx_th})
                && st_next.ctrl.tx_irq_en)
            || ((st_next.rx_cnt > {1'b0, st_next.ctrl.rx_th})
                && st_next.ctrl.rx_irq_en)
            || (|(st_next.evt & st_next.mask));
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_reg          <= '0;
            st_reg.rx_ready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fifo memories

    // four entries per direction, own pointers and counters
    fifo_byte_mem u_tx_mem (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .wr_en_i    (tx_we),
        .wr_addr_i  (tx_waddr),
        .wr_data_i  (reg_req_i.wdata),
        .rd_addr_i  (st_next.tx_rd),
        .rd_data_o  (tx_rdata)
    );

    fifo_byte_mem u_rx_mem (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .wr_en_i    (rx_we),
        .wr_addr_i  (st_reg.rx_wr),
        .wr_data_i  (rx_data_i),
        .rd_addr_i  (st_next.rx_rd),
        .rd_data_o  (rx_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign rd_data_o  = st_reg.rd_data;
    assign tx_valid_o = st_reg.tx_valid;
    assign tx_data_o  = tx_rdata;
    assign rx_ready_o = st_reg.rx_ready;
    assign irq_o      = st_reg.irq;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    tx_push_count_a: assert property (
        data_wr && tx_not_full && !tx_pop_i && !st_reg.ctrl.tx_flush
        |=> st_reg.tx_cnt == $past(st_reg.tx_cnt) + `CNT_ONE)
        else $error("transmit write did not add an entry");

    // full write keeps the count and flags the overwrite
    tx_overwrite_keep_a: assert property (
        data_wr && !tx_not_full && !tx_pop_i && !st_reg.ctrl.tx_flush
        |=> st_reg.tx_cnt == `FIFO_DEPTH && st_reg.evt.tx_overwrite)
        else $error("full transmit write changed the count");

    // empty read repeats the last byte
    rx_empty_repeat_a: assert property (
        data_rd && rx_empty
        |=> rd_data_o == $past(st_reg.last_rx))
        else $error("empty receive read did not repeat last byte");

    // enabled transmit request drives the interrupt
    tx_irq_level_a: assert property (
        tx_req && st_reg.ctrl.tx_irq_en |-> irq_o)
        else $error("transmit request did not raise interrupt");

    irq_quiet_a: assert property (
        !st_reg.ctrl.tx_irq_en && !st_reg.ctrl.rx_irq_en
        && !(|(st_reg.evt & st_reg.mask)) |-> !irq_o)
        else $error("interrupt high with no enabled cause");

    // transmit flush empties and clears in one cycle
    tx_flush_done_a: assert property (
        st_reg.ctrl.tx_flush && !ctrl_wr
        |=> st_reg.tx_cnt == `CNT_ZERO && !st_reg.ctrl.tx_flush
            && !tx_valid_o)
        else $error("transmit flush did not complete in one cycle");

    tx_req_empty_a: assert property (
        st_reg.tx_cnt == `CNT_ZERO |-> tx_req)
        else $error("empty transmit fifo without request");

    // threshold zero never requests with data queued
    tx_req_zero_a: assert property (
        st_reg.ctrl.tx_th == 2'h0 && st_reg.tx_cnt != `CNT_ZERO
        |-> !tx_req)
        else $error("threshold zero request with data queued");

    // enabled receive request drives the interrupt
    rx_irq_level_a: assert property (
        rx_req && st_reg.ctrl.rx_irq_en |-> irq_o)
        else $error("receive request did not raise interrupt");

    // a data read pops one byte and returns the head
    rx_pop_count_a: assert property (
        data_rd && !rx_empty && !rx_push_i && !st_reg.ctrl.rx_flush
        |=> st_reg.rx_cnt == $past(st_reg.rx_cnt) - `CNT_ONE
            && rd_data_o == $past(rx_rdata))
        else $error("receive read did not pop the head");

    // receive flush empties and clears in one cycle
    rx_flush_done_a: assert property (
        st_reg.ctrl.rx_flush && !ctrl_wr
        |=> rx_empty && !st_reg.ctrl.rx_flush && rx_ready_o)
        else $error("receive flush did not complete in one cycle");

    // threshold zero requests on any data
    rx_req_any_a: assert property (
        st_reg.ctrl.rx_th == 2'h0 && !rx_empty |-> rx_req)
        else $error("receive data without request at threshold zero");

    tx_not_full_a: assert property (
        data_wr && !tx_pop_i && !st_reg.ctrl.tx_flush
        && st_reg.tx_cnt == `FIFO_DEPTH - `CNT_ONE
        |=> !tx_not_full)
        else $error("transmit fifo filled but still not full");

    fifo_bound_a: assert property (
        st_reg.tx_cnt <= `FIFO_DEPTH && st_reg.rx_cnt <= `FIFO_DEPTH)
        else $error("fifo counter above depth");

    tx_overwrite_c: cover property (data_wr && !tx_not_full);
    rx_underrun_c:  cover property (data_rd && rx_empty);
    tx_flush_c:     cover property (st_reg.ctrl.tx_flush && tx_valid_o);
    irq_rise_c:     cover property (!irq_o ##1 irq_o);

endmodule : smbus_tx_rx_fifo_port

// >>> tb_top.sv
// self-checking bench for the smbus fifo port
`timescale 1ns/1ps
`include "smbus_fifo_regs.svh"

module tb_top
    import smbus_fifo_pkg::*;
;
    logic     core_clk_i;
    logic     reset_i;
    reg_req_t reg_req;
    byte_t    rd_data;
    logic     tx_pop;
    logic     tx_valid;
    byte_t    tx_data;
    logic     rx_push;
    byte_t    rx_data;
    logic     rx_ready;
    logic     irq;
    int       miscompares;
    int       check_count;
    byte_t    val;
    logic     ok;

    smbus_tx_rx_fifo_port uut (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .reg_req_i  (reg_req),
        .rd_data_o  (rd_data),
        .tx_pop_i   (tx_pop),
        .tx_valid_o (tx_valid),
        .tx_data_o  (tx_data),
        .rx_push_i  (rx_push),
        .rx_data_i  (rx_data),
        .rx_ready_o (rx_ready),
        .irq_o      (irq)
    );

    smbus_engine_model eng (
        .core_clk_i (core_clk_i),
        .tx_valid_i (tx_valid),
        .tx_data_i  (tx_data),
        .tx_pop_o   (tx_pop),
        .rx_ready_i (rx_ready),
        .rx_push_o  (rx_push),
        .rx_data_o  (rx_data)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input byte_t exp, input byte_t got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input byte_t d);
        @(posedge core_clk_i);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        reg_req <= '0;
    endtask : reg_wr

    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output byte_t d);
        @(posedge core_clk_i);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i);
        reg_req <= '0;
        @(negedge core_clk_i);
        d = rd_data;
    endtask : reg_rd

    function automatic byte_t stat_exp(input int tc, rc, tth, rth);
        return {tc <= tth, tc != 4, 2'b00, rc > rth, rc == 0, 2'b00};
    endfunction : stat_exp

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        reg_rd(`CTRL_OFS, val);
        check("control", 8'h00, val);
        reg_wr(`STAT_OFS, 8'h00);
        reg_rd(`STAT_OFS, val);
        check("status", 8'hC4, val);
        @(negedge core_clk_i);
        check("read data idle", 8'h00, rd_data);
        reg_wr(8'h10, 8'hFF);
        reg_rd(8'h10, val);
        check("unmapped", 8'h00, val);
        check("outputs", 8'h02, {5'h0, tx_valid, rx_ready, irq});
        $display("test reset done");
    endtask : t_reset

    task automatic t_tx_order();
        reg_wr(`DATA_OFS, 8'h11);
        reg_wr(`DATA_OFS, 8'h22);
        reg_wr(`DATA_OFS, 8'h33);
        reg_wr(`DATA_OFS, 8'h44);
        reg_rd(`STAT_OFS, val);
        check("status full", stat_exp(4, 0, 0, 0), val);
        reg_wr(`DATA_OFS, 8'h55);
        reg_rd(`EVT_OFS, val);
        check("overwrite event", 8'h01, val);
        eng.pop_byte(0, val, ok);
        check("tx byte 0", 8'h11, val);
        check("tx valid", 8'h01, {7'h0, ok});
        eng.pop_byte(2, val, ok);
        check("tx byte 1", 8'h22, val);
        eng.pop_byte(0, val, ok);
        check("tx byte 2", 8'h33, val);
        eng.pop_byte(0, val, ok);
        check("tx byte 3", 8'h55, val);
        @(negedge core_clk_i);
        check("tx drained", 8'h00, {7'h0, tx_valid});
        $display("test tx order done");
    endtask : t_tx_order

    task automatic t_tx_thresh();
        for (int th = 0; th < 4; th++) begin
            reg_wr(`CTRL_OFS, 8'hC0 | byte_t'(th << 4));
            for (int k = 0; k < 5; k++) begin
                if (k > 0) reg_wr(`DATA_OFS, byte_t'(k));
                reg_rd(`STAT_OFS, val);
                check("tx request", stat_exp(k, 0, th, 0), val);
                check("tx irq", 8'(k <= th), {7'h0, irq});
            end
        end
        reg_wr(`CTRL_OFS, 8'h70);
        reg_rd(`CTRL_OFS, val);
        check("flush clears", 8'h30, val);
        reg_rd(`STAT_OFS, val);
        check("tx flushed", 8'hC4, val);
        check("tx irq off", 8'h00, {6'h0, tx_valid, irq});
        $display("test tx threshold done");
    endtask : t_tx_thresh

    task automatic t_rx();
        for (int th = 0; th < 4; th++) begin
            reg_wr(`CTRL_OFS, 8'h0C | byte_t'(th));
            for (int k = 0; k < 5; k++) begin
                if (k > 0) eng.push_byte(8'hA0 + byte_t'(k));
                reg_rd(`STAT_OFS, val);
                check("rx request", stat_exp(0, k, 0, th), val);
                check("rx irq", 8'(k > th), {7'h0, irq});
                check("rx ready", 8'(k != 4), {7'h0, rx_ready});
            end
        end
        for (int k = 1; k < 5; k++) begin
            reg_rd(`DATA_OFS, val);
            check("rx byte", 8'hA0 + byte_t'(k), val);
        end
        reg_rd(`DATA_OFS, val);
        check("empty read", 8'hA4, val);
        reg_rd(`EVT_OFS, val);
        check("underrun event", 8'h02, val);
        $display("test rx done");
    endtask : t_rx

    task automatic t_events();
        reg_wr(`CTRL_OFS, 8'h04);
        for (int k = 0; k < 5; k++) eng.push_byte(8'h60 + byte_t'(k));
        reg_wr(`MASK_OFS, 8'h04);
        reg_rd(`MASK_OFS, val);
        check("mask", 8'h04, val);
        check("event irq", 8'h01, {7'h0, irq});
        reg_rd(`EVT_OFS, val);
        check("overflow event", 8'h04, val);
        check("irq cleared", 8'h00, {7'h0, irq});
        reg_rd(`DATA_OFS, val);
        check("rx head kept", 8'h60, val);
        reg_wr(`CTRL_OFS, 8'h04);
        reg_rd(`STAT_OFS, val);
        check("rx flushed", 8'hC4, val);
        reg_wr(`MASK_OFS, 8'h00);
        $display("test events done");
    endtask : t_events

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // a hang counts as a mismatch and still reaches the verdict
    initial begin
        repeat (20000) @(posedge core_clk_i);
        miscompares++;
        $display("Error run length expected finish seen timeout");
        complete_run();
    end

    initial begin
        miscompares = 0;
        check_count = 0;
        reset_i = 1'b1;
        reg_req = '0;
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_tx_order();
        t_tx_thresh();
        t_rx();
        t_events();
        complete_run();
    end

endmodule : tb_top
